// >>> design/nt_err_db.sv
`timescale 1ns/1ns
module nt_err_db (
  // clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 arst_n,
  // software-triggered function reset, one-cycle pulse
  input  wire logic                                 sw_rst,
  // wishbone classic slave
  input  wire logic                                 wb_cyc,
  input  wire logic                                 wb_stb,
  input  wire logic                                 wb_we,
  input  wire logic [nt_err_db_pkg::ADR_W-1:0]      wb_adr,
  input  wire logic [nt_err_db_pkg::SEL_W-1:0]      wb_sel,
  input  wire logic [nt_err_db_pkg::DATA_W-1:0]     wb_dat_w,
  output logic      [nt_err_db_pkg::DATA_W-1:0]     wb_dat_r,
  output logic                                      wb_ack,
  // per-port recorded errors from the internal error status pair
  input  wire logic [31:0]                          err_sts,
  output logic                                      err_report,
  // outbound doorbells
  input  wire logic [31:0]                          db_done,
  output logic [31:0]                               db_req,
  // interrupt
  output logic                                      irq
);

  nt_err_db_pkg::state_s st_r;
  nt_err_db_pkg::state_s st_nxt;

  logic [31:0] be_mask;
  logic        acc;
  logic        wr_now;
  logic        rd_now;
  logic        hit_mask;
  logic        hit_db;
  logic        hit_sts;
  logic        hit_msk;
  logic [31:0] rdata;
  logic [31:0] db_set;
  logic [1:0]  ev;
  logic [1:0]  sts_clr;
  logic        rpt_now;

  // byte enables widened to bit enables
  genvar g;
  generate
    for (g = 0; g < nt_err_db_pkg::SEL_W; g++) begin : g_be
      assign be_mask[g*8 +: 8] = {8{wb_sel[g]}};
    end
  endgenerate

  // address decode on aligned words
  assign hit_mask = wb_adr[11:2] == nt_err_db_pkg::MASK_OFF[11:2];
  assign hit_db   = wb_adr[11:2] == nt_err_db_pkg::DB_SET_OFF[11:2];
  assign hit_sts  = wb_adr[11:2] == nt_err_db_pkg::IRQ_STS_OFF[11:2];
  assign hit_msk  = wb_adr[11:2] == nt_err_db_pkg::IRQ_MSK_OFF[11:2];

  assign acc    = wb_cyc & wb_stb;
  // a request takes effect at the edge where the master samples ack
  assign wr_now = acc & st_r.ack & wb_we;
  assign rd_now = acc & st_r.ack & ~wb_we;

  always_comb begin
    rdata = nt_err_db_pkg::ZERO_W;
    if (hit_mask) begin
      rdata = st_r.mask & nt_err_db_pkg::MASK_IMPL;
    end else if (hit_db) begin
      rdata = nt_err_db_pkg::ZERO_W;
    end else if (hit_sts) begin
      rdata = {30'h00000000, st_r.sts};
    end else if (hit_msk) begin
      rdata = {30'h00000000, st_r.msk};
    end
  end

  // ones written to doorbell set; zeros contribute nothing
  assign db_set  = (wr_now && hit_db) ? (wb_dat_w & be_mask)
                                      : nt_err_db_pkg::ZERO_W;
  // status is an input only: masking never touches it
  assign rpt_now = |(err_sts & ~st_r.mask
                     & nt_err_db_pkg::MASK_IMPL);

  always_comb begin
    st_nxt = st_r;
    ev     = nt_err_db_pkg::IRQ_ZERO;
    sts_clr = nt_err_db_pkg::IRQ_ZERO;
    st_nxt.ack = 1'b0;
    if (acc && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.dat = rdata;
    end
    // implemented port bits only; reserved bits stay zero
    if (wr_now && hit_mask) begin
      st_nxt.mask = (st_r.mask & ~(be_mask & nt_err_db_pkg::MASK_IMPL))
                  | (wb_dat_w & be_mask & nt_err_db_pkg::MASK_IMPL);
    end
    // a new set wins over a completion in the same cycle
    st_nxt.db = (st_r.db & ~db_done) | db_set;
    st_nxt.rpt = rpt_now;
    ev[nt_err_db_pkg::IRQ_DB_BIT]  = |db_set;
    ev[nt_err_db_pkg::IRQ_ERR_BIT] = rpt_now & ~st_r.rpt;
    // clear only what the read returned, so a fresh event is kept
    if (rd_now && hit_sts) begin
      sts_clr = st_r.dat[1:0];
    end
    st_nxt.sts = (st_r.sts & ~sts_clr) | ev;
    if (wr_now && hit_msk) begin
      if (wb_sel[0]) begin
        st_nxt.msk = wb_dat_w[1:0];
      end
    end
    // soft reset leaves the port mask alone
    if (sw_rst) begin
      st_nxt.db  = nt_err_db_pkg::ZERO_W;
      st_nxt.sts = nt_err_db_pkg::IRQ_ZERO;
      st_nxt.msk = nt_err_db_pkg::IRQ_MSK_RST;
      st_nxt.rpt = 1'b0;
    end
    st_nxt.irq = |(st_nxt.sts & ~st_nxt.msk);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= nt_err_db_pkg::STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack     = st_r.ack;
  assign wb_dat_r   = st_r.dat;
  assign err_report = st_r.rpt;
  assign db_req     = st_r.db;
  assign irq        = st_r.irq;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_db_write;
    wb_cyc && wb_stb && wb_we && wb_ack && hit_db;
  endsequence

  sequence s_mask_write;
    wb_cyc && wb_stb && wb_we && wb_ack && hit_mask;
  endsequence

  a_ack_single: assert property (
    wb_ack |=> !wb_ack)
    else $error("ack held for more than one cycle");

  a_db_read_zero: assert property (
    wb_ack && !wb_we && hit_db |-> wb_dat_r == nt_err_db_pkg::ZERO_W)
    else $error("doorbell set read returned non-zero");

  a_db_set_bits: assert property (
    s_db_write and (!sw_rst)
    |=> (db_req & $past(wb_dat_w & be_mask)) == $past(wb_dat_w & be_mask))
    else $error("written doorbell bit not raised");

  a_db_zero_keep: assert property (
    s_db_write and (!sw_rst)
    |=> (db_req & $past(st_r.db & ~db_done)) == $past(st_r.db & ~db_done))
    else $error("doorbell cleared by a zero write");

  a_mask_reserved: assert property (
    (st_r.mask & ~nt_err_db_pkg::MASK_IMPL) == nt_err_db_pkg::ZERO_W)
    else $error("reserved mask bit set");

  a_mask_soft_keep: assert property (
    sw_rst && !(wb_cyc && wb_stb && wb_we && wb_ack && hit_mask)
    |=> st_r.mask == $past(st_r.mask))
    else $error("soft reset changed port mask");

  a_mask_write: assert property (
    s_mask_write and (&wb_sel)
    |=> st_r.mask == ($past(wb_dat_w) & nt_err_db_pkg::MASK_IMPL))
    else $error("port mask write not stored");

  a_full_mask_quiet: assert property (
    st_r.mask == nt_err_db_pkg::MASK_IMPL |=> !err_report)
    else $error("report raised while every port masked");

  a_unmasked_report: assert property (
    (err_sts & ~st_r.mask & nt_err_db_pkg::MASK_IMPL) != nt_err_db_pkg::ZERO_W
    && !sw_rst |=> err_report)
    else $error("unmasked port error not reported");

  a_irq_follows: assert property (
    s_db_write and ((wb_dat_w & be_mask) != nt_err_db_pkg::ZERO_W
    && !sw_rst && !st_r.msk[nt_err_db_pkg::IRQ_DB_BIT]) |=> irq)
    else $error("doorbell event raised no interrupt");

  sequence s_mask_read;
    wb_cyc && wb_stb && !wb_we && wb_ack && hit_mask;
  endsequence

  sequence s_db_read;
    wb_cyc && wb_stb && !wb_we && wb_ack && hit_db;
  endsequence

  // a full-word write that opens every port, then a live error
  sequence s_mask_cleared;
    (wb_cyc && wb_stb && wb_we && wb_ack && hit_mask && (&wb_sel)
     && (wb_dat_w & nt_err_db_pkg::MASK_IMPL) == nt_err_db_pkg::ZERO_W)
    ##1 ((err_sts & nt_err_db_pkg::MASK_IMPL) != nt_err_db_pkg::ZERO_W
         && !sw_rst);
  endsequence

  // a full-word write that closes every port, then one settling cycle
  sequence s_mask_filled;
    (wb_cyc && wb_stb && wb_we && wb_ack && hit_mask && (&wb_sel)
     && (wb_dat_w & nt_err_db_pkg::MASK_IMPL) == nt_err_db_pkg::MASK_IMPL)
    ##1 1'b1;
  endsequence

  a_ack_answer: assert property (
    wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("register request not answered");

  a_mask_rsvd_read: assert property (
    s_mask_read |-> (wb_dat_r & ~nt_err_db_pkg::MASK_IMPL)
                    == nt_err_db_pkg::ZERO_W)
    else $error("reserved mask bit read as one");

  a_mask_readback: assert property (
    s_mask_read |-> wb_dat_r == st_r.mask)
    else $error("port mask read differs from stored mask");

  a_mask_hold: assert property (
    !(wb_cyc && wb_stb && wb_we && wb_ack && hit_mask)
    |=> st_r.mask == $past(st_r.mask))
    else $error("port mask changed without a write");

  a_mask_bytes: assert property (
    s_mask_write |=> (st_r.mask & ~$past(be_mask))
                     == ($past(st_r.mask) & ~$past(be_mask)))
    else $error("mask write touched a disabled byte");

  a_low_ports: assert property (
    s_mask_write and (&wb_sel)
    |=> (st_r.mask & nt_err_db_pkg::PORT_GRP_LO)
        == ($past(wb_dat_w) & nt_err_db_pkg::PORT_GRP_LO))
    else $error("ports 0 to 3 mask not stored");

  a_mid_ports: assert property (
    s_mask_write and (&wb_sel)
    |=> (st_r.mask & nt_err_db_pkg::PORT_GRP_MID)
        == ($past(wb_dat_w) & nt_err_db_pkg::PORT_GRP_MID))
    else $error("ports 8 to 11 mask not stored");

  a_high_ports: assert property (
    s_mask_write and (&wb_sel)
    |=> (st_r.mask & nt_err_db_pkg::PORT_GRP_HI)
        == ($past(wb_dat_w) & nt_err_db_pkg::PORT_GRP_HI))
    else $error("ports 16 to 19 mask not stored");

  a_masked_silent: assert property (
    (err_sts & ~st_r.mask & nt_err_db_pkg::MASK_IMPL)
    == nt_err_db_pkg::ZERO_W |=> !err_report)
    else $error("report raised with every error masked");

  a_unimpl_silent: assert property (
    (err_sts & nt_err_db_pkg::MASK_IMPL) == nt_err_db_pkg::ZERO_W
    |=> !err_report)
    else $error("report raised by a port without a mask bit");

  a_open_report: assert property (
    s_mask_cleared |=> err_report)
    else $error("error not reported after unmasking");

  a_closed_quiet: assert property (
    s_mask_filled |=> !err_report)
    else $error("report raised after masking every port");

  a_db_no_stray: assert property (
    !(wb_cyc && wb_stb && wb_we && wb_ack && hit_db)
    |=> (db_req & ~$past(db_req)) == nt_err_db_pkg::ZERO_W)
    else $error("doorbell raised without a write");

  a_db_hold: assert property (
    db_done == nt_err_db_pkg::ZERO_W && !sw_rst
    |=> (db_req & $past(db_req)) == $past(db_req))
    else $error("pending doorbell dropped without completion");

  a_db_done_clear: assert property (
    !(wb_cyc && wb_stb && wb_we && wb_ack && hit_db)
    |=> (db_req & $past(db_done)) == nt_err_db_pkg::ZERO_W)
    else $error("completed doorbell still pending");

  a_db_read_quiet: assert property (
    s_db_read and (db_done == nt_err_db_pkg::ZERO_W && !sw_rst)
    |=> db_req == $past(db_req))
    else $error("doorbell set read changed requests");

endmodule

// >>> design/nt_err_db_pkg.sv
package nt_err_db_pkg;

  // bus geometry
  localparam int          DATA_W   = 32;
  localparam int          ADR_W    = 12;
  localparam int          SEL_W    = DATA_W / 8;

  // register byte offsets
  localparam logic [11:0] MASK_OFF    = 12'h418;
  localparam logic [11:0] DB_SET_OFF  = 12'h420;
  localparam logic [11:0] IRQ_STS_OFF = 12'h410;
  localparam logic [11:0] IRQ_MSK_OFF = 12'h414;

  // per-port mask field layout: ports 0-3, 8-11, 16-19
  localparam logic [31:0] MASK_IMPL = 32'h000F0F0F;
  localparam logic [31:0] MASK_RST  = 32'h000F0F0F;
  localparam logic [31:0] ZERO_W    = 32'h00000000;

  // port groups of the mask: 0-3, 8-11, 16-19
  localparam logic [31:0] PORT_GRP_LO  = 32'h0000000F;
  localparam logic [31:0] PORT_GRP_MID = 32'h00000F00;
  localparam logic [31:0] PORT_GRP_HI  = 32'h000F0000;

  // interrupt status and mask layout
  localparam int          IRQ_W       = 2;
  localparam int          IRQ_DB_BIT  = 0;
  localparam int          IRQ_ERR_BIT = 1;
  localparam logic [1:0]  IRQ_MSK_RST = 2'h0;
  localparam logic [1:0]  IRQ_ZERO    = 2'h0;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] db;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        ack;
    logic [31:0] dat;
    logic        rpt;
    logic        irq;
  } state_s;

  localparam state_s STATE_RST = '{
    mask: MASK_RST,
    db:   ZERO_W,
    sts:  IRQ_ZERO,
    msk:  IRQ_MSK_RST,
    ack:  1'b0,
    dat:  ZERO_W,
    rpt:  1'b0,
    irq:  1'b0
  };

endpackage

// >>> dv/tb.sv
`timescale 1ns/1ns
module tb;
  logic        mclk     = 1'b0;
  logic        arst_n   = 1'b0;
  logic        sw_rst   = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [11:0] wb_adr   = 12'h000;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [31:0] err_sts  = 32'h0;
  logic        err_report;
  logic [31:0] db_done  = 32'h0;
  logic [31:0] db_req;
  logic        irq;
  logic [31:0] rd;
  logic [3:0]  sel_w    = 4'hF;
  int          bad_count = 0;
  int          compares  = 0;
  int          ports [12] = '{0, 1, 2, 3, 8, 9, 10, 11, 16, 17, 18, 19};

  always #2 mclk = ~mclk;

  nt_err_db DUT (.mclk(mclk), .arst_n(arst_n), .sw_rst(sw_rst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .err_sts(err_sts), .err_report(err_report),
    .db_done(db_done), .db_req(db_req), .irq(irq));

  task automatic conclude;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one classic cycle; read data lands in rd
  task automatic xfer(input logic we, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= sel_w;
    wb_dat_w <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    step(1);
  endtask

  initial begin
    step(5);
    arst_n <= 1'b1;
    step(1);
    xfer(1'b0, 12'h418, 32'h0);
    check("mask_rst", rd, 32'h000F0F0F);
    xfer(1'b1, 12'h418, 32'hFFFFFFFF);
    xfer(1'b0, 12'h418, 32'h0);
    check("mask_rsvd", rd, 32'h000F0F0F);
    xfer(1'b1, 12'h418, 32'h0);
    foreach (ports[i]) begin
      err_sts <= 32'h1 << ports[i];
      step(2);
      check("err_open", {31'h0, err_report}, 32'h1);
      xfer(1'b1, 12'h418, 32'h1 << ports[i]);
      step(1);
      check("err_masked", {31'h0, err_report}, 32'h0);
      xfer(1'b1, 12'h418, 32'h0);
    end
    err_sts <= 32'h0000F0F0;
    step(2);
    check("err_unimpl", {31'h0, err_report}, 32'h0);
    err_sts <= 32'h0;
    xfer(1'b0, 12'h410, 32'h0);
    check("irq_sts_err", rd, 32'h2);
    xfer(1'b1, 12'h420, 32'h80000001);
    check("db_set", db_req, 32'h80000001);
    check("irq_db", {31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h420, 32'h0);
    check("db_zero", db_req, 32'h80000001);
    xfer(1'b0, 12'h420, 32'h0);
    check("db_read", rd, 32'h0);
    xfer(1'b1, 12'h420, 32'h00010000);
    check("db_more", db_req, 32'h80010001);
    db_done <= 32'h00000001;
    step(1);
    db_done <= 32'h0;
    step(1);
    check("db_done", db_req, 32'h80010000);
    xfer(1'b0, 12'h410, 32'h0);
    check("irq_sts_db", rd, 32'h1);
    step(1);
    check("irq_clr", {31'h0, irq}, 32'h0);
    xfer(1'b1, 12'h414, 32'h1);
    xfer(1'b1, 12'h420, 32'h4);
    step(1);
    check("irq_blocked", {31'h0, irq}, 32'h0);
    xfer(1'b0, 12'h410, 32'h0);
    check("irq_sts_msk", rd, 32'h1);
    xfer(1'b1, 12'h7FC, 32'hFFFFFFFF);
    xfer(1'b0, 12'h7FC, 32'h0);
    check("unmapped", rd, 32'h0);
    xfer(1'b1, 12'h418, 32'h00000F00);
    sw_rst <= 1'b1;
    step(1);
    sw_rst <= 1'b0;
    step(1);
    check("db_swrst", db_req, 32'h0);
    xfer(1'b0, 12'h418, 32'h0);
    check("mask_sticky", rd, 32'h00000F00);
    sel_w = 4'h1;
    xfer(1'b1, 12'h418, 32'h000F000F);
    sel_w = 4'hF;
    xfer(1'b0, 12'h418, 32'h0);
    check("mask_bytes", rd, 32'h00000F0F);
    xfer(1'b0, 12'h414, 32'h0);
    check("irqmsk_swrst", rd, 32'h0);
    arst_n <= 1'b0;
    step(2);
    arst_n <= 1'b1;
    step(1);
    xfer(1'b0, 12'h418, 32'h0);
    check("mask_hard", rd, 32'h000F0F0F);
    conclude();
  end
endmodule
